/* File: verilog/ppdb_pkg.sv */
// Purpose: Shared constants for the pixel processor double-buffered register set.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Register indices and command codes are local to this block.
`default_nettype none
package ppdb_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int REG_CNT   = 4;
  localparam int IDX_W     = 2;
  localparam int DATA_W    = 16;
  localparam int LAYER_W   = 4;
  localparam int CMD_W     = 4;

  // ****************************************
  // Register indices
  // ****************************************
  localparam logic [IDX_W-1:0] IDX_LAYER  = 2'h0;  // Bits [3:0] layer, bit 4 use flag.
  localparam logic [IDX_W-1:0] IDX_MISC0  = 2'h1;
  localparam logic [IDX_W-1:0] IDX_MISC1  = 2'h2;
  localparam logic [IDX_W-1:0] IDX_MISC2  = 2'h3;
  localparam int               LAYER_LSB  = 0;
  localparam int               ULAY_BIT   = 4;
  localparam logic [DATA_W-1:0] REG_RST   = 16'h0000;
  localparam logic             RSEL_RST   = 1'b0;

  // ****************************************
  // Commands
  // ****************************************
  localparam logic [CMD_W-1:0] CMD_PUT_SINGLE_PIXEL   = 4'h0;
  localparam logic [CMD_W-1:0] CMD_PUT_PIXEL_WORD     = 4'h1;
  localparam logic [CMD_W-1:0] CMD_PUT_PIXEL_FIXED    = 4'h2;
  localparam logic [CMD_W-1:0] CMD_GET_SINGLE_PIXEL   = 4'h3;
  localparam logic [CMD_W-1:0] CMD_EXCHANGE_PIXEL     = 4'h4;
  localparam logic [CMD_W-1:0] CMD_DRAW_LINE          = 4'h5;
  localparam logic [CMD_W-1:0] CMD_DRAW_RECTANGLE     = 4'h6;
  localparam logic [CMD_W-1:0] CMD_DRAW_POLYGON       = 4'h7;
endpackage
`default_nettype wire

/* File: verilog/ppdb_layer_sel.sv */
// Purpose: Picks the target layer for one pixel address of a drawing command.
// Assumes: Command code and working copy are stable during the command.
// Notes:   Pure combinational leaf used by the register bank.
`default_nettype none
module ppdb_layer_sel
(
  // Command and working copy
  input  wire logic [3:0] cmd,
  input  wire logic       use_layer_register,
  input  wire logic [3:0] target_layer_select,
  // Layer carried in the pixel address
  input  wire logic [3:0] addr_layer,
  // Result
  output logic      [3:0] layer
);
  // ****************************************
  // Selection
  // ****************************************
  // The five pixel-access commands have their own layer path, so the register never applies.
  function automatic logic is_pixel_access(input logic [3:0] c);
    is_pixel_access = (c == ppdb_pkg::CMD_PUT_SINGLE_PIXEL) ||
                      (c == ppdb_pkg::CMD_PUT_PIXEL_WORD) ||
                      (c == ppdb_pkg::CMD_PUT_PIXEL_FIXED) ||
                      (c == ppdb_pkg::CMD_GET_SINGLE_PIXEL) ||
                      (c == ppdb_pkg::CMD_EXCHANGE_PIXEL);
  endfunction

  // Register layer only for area commands with the use flag set.
  always_comb
  begin
    if (is_pixel_access(cmd))
      layer = addr_layer;
    else if (use_layer_register)
      layer = target_layer_select;
    else
      layer = addr_layer;
  end
endmodule
`default_nettype wire

/* File: verilog/ppdb_regbank.sv */
// Purpose: Double-buffered pixel processor registers with target layer selection.
// Assumes: Host writes and reads through a simple synchronous register port.
// Notes:   Working copies load only when a command starts, never mid-command.
//
// Functional notes
// - Pixel-access commands take their layer only from the pixel address, ignoring the register.
// - Line, rectangle and polygon use the layer register when its use bit is 1.
// - Host writes change only the configuration copy, never the working copy.
// - Hardware copies configuration to working registers in step with command start.
// - Reads return the configuration copy when the read select is 1, else the working copy.
// - The read select resets to 0.
`default_nettype none
module ppdb_regbank
#(
  parameter int DATA_W = ppdb_pkg::DATA_W
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              srst,
  // Host register port
  input  wire logic              wr_en,
  input  wire logic              rd_en,
  input  wire logic [1:0]        addr,
  input  wire logic [DATA_W-1:0] wdata,
  output logic      [DATA_W-1:0] rdata,
  output logic                   rvalid,
  // Read source setting
  input  wire logic              rsel_wr,
  input  wire logic              rsel_val,
  output logic                   read_source_select,
  // Command execution
  input  wire logic              cmd_start,
  input  wire logic              cmd_done,
  input  wire logic [3:0]        cmd_code,
  input  wire logic              pix_valid,
  input  wire logic [3:0]        pix_addr_layer,
  output logic                   cmd_busy,
  output logic      [3:0]        pix_layer,
  output logic                   pix_layer_valid
);
  // ****************************************
  // Storage
  // ****************************************
  logic [DATA_W-1:0] cfg_q  [ppdb_pkg::REG_CNT];
  logic [DATA_W-1:0] work_q [ppdb_pkg::REG_CNT];
  logic              rsel_q;
  logic              busy_q;
  logic [3:0]        cmd_q;
  logic [3:0]        layer_d;

  // Host writes land only in the configuration copy.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < ppdb_pkg::REG_CNT; i++)
        cfg_q[i] <= ppdb_pkg::REG_RST;
    end
    else if (wr_en)
      cfg_q[addr] <= wdata;
  end

  // Working copy loads at command start only; a busy command keeps its values.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      for (int i = 0; i < ppdb_pkg::REG_CNT; i++)
        work_q[i] <= ppdb_pkg::REG_RST;
    end
    else if (cmd_start && !busy_q)
    begin
      for (int i = 0; i < ppdb_pkg::REG_CNT; i++)
        work_q[i] <= cfg_q[i];
    end
  end

  // Command tracking; start is ignored while a command still runs.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      busy_q <= 1'b0;
      cmd_q  <= 4'h0;
    end
    else if (cmd_start && !busy_q)
    begin
      busy_q <= 1'b1;
      cmd_q  <= cmd_code;
    end
    else if (cmd_done)
      busy_q <= 1'b0;
  end

  // Read source select.
  always_ff @(posedge clk)
  begin
    if (srst)
      rsel_q <= ppdb_pkg::RSEL_RST;
    else if (rsel_wr)
      rsel_q <= rsel_val;
  end

  // Register reads, one cycle after the request.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      rdata  <= '0;
      rvalid <= 1'b0;
    end
    else
    begin
      rvalid <= rd_en;
      if (rd_en)
        rdata <= rsel_q ? cfg_q[addr] : work_q[addr];
    end
  end

  // ****************************************
  // Layer path
  // ****************************************
  // The layer register's fields always come from the working copy.
  ppdb_layer_sel ppdb_layer_sel_i
  (
    .cmd                 (cmd_q),
    .use_layer_register  (work_q[ppdb_pkg::IDX_LAYER][ppdb_pkg::ULAY_BIT]),
    .target_layer_select (work_q[ppdb_pkg::IDX_LAYER][ppdb_pkg::LAYER_LSB +: ppdb_pkg::LAYER_W]),
    .addr_layer          (pix_addr_layer),
    .layer               (layer_d)
  );

  // Registered layer result per pixel address of a running command.
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      pix_layer       <= 4'h0;
      pix_layer_valid <= 1'b0;
    end
    else
    begin
      pix_layer_valid <= pix_valid && busy_q;
      if (pix_valid && busy_q)
        pix_layer <= layer_d;
    end
  end

  // Status outputs are the flops themselves, so the host never sees a glitch.
  assign read_source_select = rsel_q;
  assign cmd_busy           = busy_q;

  // ****************************************
  // Checks
  // ****************************************
  // Layer choice for each kind of command.
  pixel_layer_a: assert property (@(posedge clk) disable iff (srst)
    (pix_valid && busy_q && cmd_q <= ppdb_pkg::CMD_EXCHANGE_PIXEL)
      |=> pix_layer == $past(pix_addr_layer))
    else $error("Pixel command did not use address layer.");
  area_layer_a: assert property (@(posedge clk) disable iff (srst)
    (pix_valid && busy_q && cmd_q > ppdb_pkg::CMD_EXCHANGE_PIXEL &&
     cmd_q <= ppdb_pkg::CMD_DRAW_POLYGON && work_q[0][ppdb_pkg::ULAY_BIT])
      |=> pix_layer == $past(work_q[0][3:0]))
    else $error("Area command did not use layer register.");
  // A pixel address outside a command must not produce a layer result.
  idle_pixel_a: assert property (@(posedge clk) disable iff (srst)
    !(pix_valid && busy_q) |=> !pix_layer_valid)
    else $error("Pixel result without a running command.");
  // Host writes reach the configuration copy and never the working copy.
  write_cfg_a: assert property (@(posedge clk) disable iff (srst)
    wr_en |=> cfg_q[$past(addr)] == $past(wdata))
    else $error("Configuration copy not written.");
  work_stable_a: assert property (@(posedge clk) disable iff (srst)
    !(cmd_start && !busy_q) |=> $stable(work_q[0]) && $stable(work_q[1]) &&
                                $stable(work_q[2]) && $stable(work_q[3]))
    else $error("Working copy changed outside a command start.");
  // The working copy loads only at an accepted command start.
  load_start_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_start && !busy_q) |=> work_q[1] == $past(cfg_q[1]) && busy_q)
    else $error("Working copy not loaded at command start.");
  load_all_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_start && !busy_q) |=> work_q[0] == $past(cfg_q[0]) && work_q[3] == $past(cfg_q[3]))
    else $error("Working copy not fully loaded at command start.");
  start_refused_a: assert property (@(posedge clk) disable iff (srst)
    (cmd_start && busy_q && !cmd_done) |=> busy_q && $stable(cmd_q))
    else $error("Command start accepted while busy.");
  busy_end_a: assert property (@(posedge clk) disable iff (srst)
    (busy_q && cmd_done) |=> !busy_q)
    else $error("Command did not end after done.");
  // Read path and read source select.
  read_src_a: assert property (@(posedge clk) disable iff (srst)
    (rd_en && !rsel_q) |=> rdata == $past(work_q[addr]))
    else $error("Working copy read mismatch.");
  read_valid_a: assert property (@(posedge clk) disable iff (srst)
    rd_en |=> rvalid)
    else $error("Read answer missing.");
  rsel_write_a: assert property (@(posedge clk) disable iff (srst)
    rsel_wr |=> read_source_select == $past(rsel_val))
    else $error("Read select not loaded.");
  rsel_reset_a: assert property (@(posedge clk)
    srst |=> !rsel_q)
    else $error("Read select not cleared by reset.");
  busy_hold_a: assert property (@(posedge clk) disable iff (srst)
    (busy_q && !cmd_done) |=> $stable(work_q[0]) && $stable(work_q[2]))
    else $error("Working copy changed during a command.");
  read_cfg_a: assert property (@(posedge clk) disable iff (srst)
    (rd_en && rsel_q) |=> rdata == $past(cfg_q[addr]) && rvalid)
    else $error("Configuration copy read mismatch.");
endmodule
`default_nettype wire

/* File: verification/ppdb_host_model.sv */
// Purpose: Host model that drives register and command traffic.
// Assumes: Each strobe is raised on a rising edge and held one cycle.
// Notes:   Pixel addresses always carry their own layer bits.
`default_nettype none
module ppdb_host_model
(
  // Clock
  input  wire logic        clk,
  // Requests towards the register bank
  output logic             wr_en,
  output logic             rd_en,
  output logic      [1:0]  addr,
  output logic      [15:0] wdata,
  output logic             rsel_wr,
  output logic             rsel_val,
  output logic             cmd_start,
  output logic             cmd_done,
  output logic      [3:0]  cmd_code,
  output logic             pix_valid,
  output logic      [3:0]  pix_addr_layer
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // Requests
  // ****************************************
  // Everything idles low so nothing is requested during reset.
  initial
  begin
    {wr_en, rd_en, addr, wdata, rsel_wr, rsel_val} = '0;
    {cmd_start, cmd_done, cmd_code, pix_valid, pix_addr_layer} = '0;
  end
  // Each task raises one strobe for exactly one edge.
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    {wr_en, addr, wdata} <= {1'b1, a, d};
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a);
    @(posedge clk);
    {rd_en, addr} <= {1'b1, a};
    @(posedge clk);
    rd_en <= 1'b0;
  endtask
  // Sets the read source select to the given value; 1 reads the configuration copy.
  task automatic rsel(input logic v);
    @(posedge clk);
    {rsel_wr, rsel_val} <= {1'b1, v};
    @(posedge clk);
    rsel_wr <= 1'b0;
  endtask
  task automatic start(input logic [3:0] c);
    @(posedge clk);
    {cmd_start, cmd_code} <= {1'b1, c};
    @(posedge clk);
    cmd_start <= 1'b0;
  endtask
  task automatic done();
    @(posedge clk);
    cmd_done <= 1'b1;
    @(posedge clk);
    cmd_done <= 1'b0;
  endtask
  // The layer is always merged into the pixel address.
  task automatic pixel(input logic [3:0] l);
    @(posedge clk);
    {pix_valid, pix_addr_layer} <= {1'b1, l};
    @(posedge clk);
    {pix_valid, pix_addr_layer} <= {1'b0, ~l};
  endtask
endmodule
`default_nettype wire

/* File: verification/pixel_proc_dbl_buf_layer_sel_bench.sv */
// Purpose: Self-checking bench for the double-buffered register bank.
// Assumes: Host model drives every request on a rising edge.
// Notes:   Pixels carry layer 9, the layer register holds layer 5.
`default_nettype none
module pixel_proc_dbl_buf_layer_sel_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk = 1'b0;
  logic        srst, wr_en, rd_en, rsel_wr, rsel_val, cmd_start, cmd_done;
  logic        pix_valid, rvalid, read_source_select, cmd_busy, pix_layer_valid;
  logic [1:0]  addr;
  logic [3:0]  cmd_code, pix_addr_layer, pix_layer;
  logic [15:0] wdata, rdata;
  int          fail_count = 0, comparisons = 0, cyc = 0;
  ppdb_regbank ppdb_regbank_i
  (
    .clk                (clk),
    .srst               (srst),
    .wr_en              (wr_en),
    .rd_en              (rd_en),
    .addr               (addr),
    .wdata              (wdata),
    .rdata              (rdata),
    .rvalid             (rvalid),
    .rsel_wr            (rsel_wr),
    .rsel_val           (rsel_val),
    .read_source_select (read_source_select),
    .cmd_start          (cmd_start),
    .cmd_done           (cmd_done),
    .cmd_code           (cmd_code),
    .pix_valid          (pix_valid),
    .pix_addr_layer     (pix_addr_layer),
    .cmd_busy           (cmd_busy),
    .pix_layer          (pix_layer),
    .pix_layer_valid    (pix_layer_valid)
  );
  ppdb_host_model ppdb_host_model_i
  (
    .clk            (clk),
    .wr_en          (wr_en),
    .rd_en          (rd_en),
    .addr           (addr),
    .wdata          (wdata),
    .rsel_wr        (rsel_wr),
    .rsel_val       (rsel_val),
    .cmd_start      (cmd_start),
    .cmd_done       (cmd_done),
    .cmd_code       (cmd_code),
    .pix_valid      (pix_valid),
    .pix_addr_layer (pix_addr_layer)
  );
  // ****************************************
  // Clock, timeout and checks
  // ****************************************
  // Free-running 250 MHz clock.
  always #2 clk = ~clk;
  // A hang is cut short well beyond the roughly 140 cycles needed.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 2000)
    begin
      fail_count++;
      end_sim();
    end
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (e !== g)
    begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd_chk(input logic [1:0] a, input logic [15:0] e);
    ppdb_host_model_i.rd(a);
    #1;
    chk("rdata", e, {rvalid ? 16'h0 : 16'hffff} ^ rdata);
  endtask
  task automatic end_sim;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    chk("read_source_select", 16'h0, 16'(read_source_select));
    rd_chk(ppdb_pkg::IDX_LAYER, 16'h0000);
  endtask
  // Every command code, with a config write landing mid-command.
  task automatic t_layers;
    logic [15:0] exp_layer;
    for (int c = 0; c < 8; c++)
    begin
      ppdb_host_model_i.wr(ppdb_pkg::IDX_LAYER, (c == 7) ? 16'h0005 : 16'h0015);
      ppdb_host_model_i.start(4'(c));
      #1;
      chk("cmd_busy", 16'h1, 16'(cmd_busy));
      ppdb_host_model_i.wr(ppdb_pkg::IDX_LAYER, 16'h0013);
      ppdb_host_model_i.pixel(4'h9);
      #1;
      exp_layer = (c < 5 || c == 7) ? 16'h0019 : 16'h0015;
      chk("pix_layer", exp_layer, 16'({pix_layer_valid, pix_layer}));
      ppdb_host_model_i.done();
      #1;
      chk("cmd_busy", 16'h0, 16'(cmd_busy));
    end
  endtask
  // Writes stay in the configuration copy until the next command start.
  task automatic t_buffers;
    rd_chk(ppdb_pkg::IDX_LAYER, 16'h0005);
    ppdb_host_model_i.wr(ppdb_pkg::IDX_MISC0, 16'hbeef);
    rd_chk(ppdb_pkg::IDX_MISC0, 16'h0000);
    ppdb_host_model_i.rsel(1'b1);
    #1;
    chk("read_source_select", 16'h1, 16'(read_source_select));
    rd_chk(ppdb_pkg::IDX_MISC0, 16'hbeef);
    rd_chk(ppdb_pkg::IDX_LAYER, 16'h0013);
    ppdb_host_model_i.start(ppdb_pkg::CMD_DRAW_LINE);
    ppdb_host_model_i.done();
    ppdb_host_model_i.rsel(1'b0);
    rd_chk(ppdb_pkg::IDX_MISC0, 16'hbeef);
  endtask
  // A start while busy is refused, and pixels between commands give no result.
  task automatic t_refused;
    ppdb_host_model_i.start(ppdb_pkg::CMD_DRAW_RECTANGLE);
    ppdb_host_model_i.wr(ppdb_pkg::IDX_MISC1, 16'h1234);
    ppdb_host_model_i.start(ppdb_pkg::CMD_DRAW_RECTANGLE);
    #1;
    chk("cmd_busy", 16'h1, 16'(cmd_busy));
    rd_chk(ppdb_pkg::IDX_MISC1, 16'h0000);
    ppdb_host_model_i.done();
    ppdb_host_model_i.pixel(4'h2);
    #1;
    chk("pix_layer_valid", 16'h0, 16'(pix_layer_valid));
    ppdb_host_model_i.start(ppdb_pkg::CMD_DRAW_RECTANGLE);
    rd_chk(ppdb_pkg::IDX_MISC1, 16'h1234);
    ppdb_host_model_i.done();
  endtask
  // Reset for 20 cycles, then run every scenario.
  initial
  begin
    srst = 1'b1;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_layers();
    t_buffers();
    t_refused();
    end_sim();
  end
endmodule
`default_nettype wire
